/* shared/fsr_pkg.sv */
// Constants and types for the status register one logic of a serial flash.
// Assumes the link front end decodes serial transactions into pulses.
// Notes on behaviour
// - Three-bit protect size at bits 4:2, default zero
// - Size zero means nothing protected
// - Codes one, two protect four, eight sectors
// - Protected region doubles from selected end
// - Code seven protects all but sectors 254, 255
// - Lock bit makes both size copies read-only
// - Operations run only with write enable set
// - Write enable transactions set write enable
// - Write disable transaction clears write enable
// - Successful operation end clears write enable
// - Resets and deep power-down clear write enable
// - Busy flag one while operation runs
// - Error flags change only while busy; the code also sets one from idle when a start hits a protected sector
// - Error keeps busy until clear flags transaction
// - Status not valid during resets
// - Program error at bit 6, sticky
// - Erase error at bit 5, sticky
package fsr_pkg;
   localparam int BUSY_POS = 0;
   localparam int WREN_POS = 1;
   localparam int SIZE_LO = 2;
   localparam int SIZE_HI = 4;
   localparam int ERS_ERR_POS = 5;
   localparam int PRG_ERR_POS = 6;
   localparam logic [2:0] SIZE_RESET = 3'h0;
   localparam logic [8:0] SIZE_BASE_SECTORS = 9'h004;
   localparam logic [8:0] SECTOR_COUNT = 9'h100;
   localparam logic [8:0] TOP_SPARE_SECTORS = 9'h002;
   localparam logic [2:0] SIZE_ALL_BUT_TWO = 3'h7;
   typedef enum logic [2:0] {
      FSR_IDLE = 3'b001,
      FSR_RUN  = 3'b010,
      FSR_HOLD = 3'b100
   } fsr_state_type;
endpackage

/* src/fsr_protect_map.sv */
// Decodes protect size and select into a protected sector test.
// Assumes sector numbers 0..255 over the whole array.
`timescale 1ns/100ps
module fsr_protect_map (
   // Settings
   input wire logic [2:0] size_i,
   input wire logic top_select_i,
   // Query
   input wire logic [7:0] sector_i,
   output logic protected_o
);
   logic [8:0] count;
   logic [8:0] lo_bound;
   assign count = (size_i == fsr_pkg::SIZE_ALL_BUT_TWO) ?
      9'(fsr_pkg::SECTOR_COUNT - fsr_pkg::TOP_SPARE_SECTORS) :
      9'(fsr_pkg::SIZE_BASE_SECTORS << (size_i - 3'h1));
   assign lo_bound = 9'(fsr_pkg::SECTOR_COUNT - count);
   assign protected_o = (size_i == fsr_pkg::SIZE_RESET) ? 1'b0 :
      (size_i == fsr_pkg::SIZE_ALL_BUT_TWO) ?
      ({1'b0, sector_i} < count) :
      (top_select_i ? ({1'b0, sector_i} >= lo_bound) :
                      ({1'b0, sector_i} < count));
endmodule

/* src/fsr_status_one.sv */
// Status register one: protect size, write enable, busy and error flags.
// Assumes transaction pulses are decoded on the link clock by the front end.
`timescale 1ns/100ps
module fsr_status_one (
   // System
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Link clock and decoded transaction pulses
   input wire logic link_clk_i,
   input wire logic write_enable_cmd_i,
   input wire logic write_disable_cmd_i,
   input wire logic clear_flags_cmd_i,
   input wire logic size_write_cmd_i,
   input wire logic [2:0] size_data_i,
   input wire logic op_start_i,
   input wire logic op_is_erase_i,
   input wire logic [7:0] op_sector_i,
   // Embedded operation engine
   input wire logic op_done_i,
   input wire logic op_fail_i,
   // Config and lock
   input wire logic top_bottom_select_i,
   input wire logic permanent_protect_lock_i,
   input wire logic deep_power_down_i,
   // Status
   output logic [7:0] status_one_volatile_o,
   output logic [2:0] status_one_nonvolatile_size_o,
   output logic op_go_o
);
   // Link side: each pulse becomes a toggle
   logic we_tg_reg, wd_tg_reg, cl_tg_reg, sw_tg_reg, st_tg_reg;
   logic [2:0] sz_hold_reg;
   logic er_hold_reg;
   logic [7:0] sec_hold_reg;
   // Reset brought into the link domain through two flip-flops
   logic rst_l1_reg, rst_l2_reg;
   always_ff @(posedge link_clk_i) begin
      rst_l1_reg <= resetn_i;
      rst_l2_reg <= rst_l1_reg;
   end
   // Toggles start known, else the ref side never sees a clean edge
   always_ff @(posedge link_clk_i) begin
      if (!rst_l2_reg) begin
         we_tg_reg <= 1'b0;
         wd_tg_reg <= 1'b0;
         cl_tg_reg <= 1'b0;
         sw_tg_reg <= 1'b0;
         st_tg_reg <= 1'b0;
         sz_hold_reg <= fsr_pkg::SIZE_RESET;
         er_hold_reg <= 1'b0;
         sec_hold_reg <= 8'h00;
      end else begin
         we_tg_reg <= we_tg_reg ^ write_enable_cmd_i;
         wd_tg_reg <= wd_tg_reg ^ write_disable_cmd_i;
         cl_tg_reg <= cl_tg_reg ^ clear_flags_cmd_i;
         sw_tg_reg <= sw_tg_reg ^ size_write_cmd_i;
         st_tg_reg <= st_tg_reg ^ op_start_i;
         if (size_write_cmd_i) begin
            sz_hold_reg <= size_data_i;
         end
         if (op_start_i) begin
            er_hold_reg <= op_is_erase_i;
            sec_hold_reg <= op_sector_i;
         end
      end
   end

   // Two-stage synchronisers plus edge history
   logic [4:0] tg_s1_reg, tg_s2_reg, tg_s3_reg;
   logic [2:0] tcb_s1_reg, tcb_s2_reg;
   always_ff @(posedge ref_clk_i) begin
      tg_s1_reg <= {st_tg_reg, sw_tg_reg, cl_tg_reg, wd_tg_reg, we_tg_reg};
      tg_s2_reg <= tg_s1_reg;
      tg_s3_reg <= tg_s2_reg;
      tcb_s1_reg <= {deep_power_down_i, permanent_protect_lock_i,
                     top_bottom_select_i};
      tcb_s2_reg <= tcb_s1_reg;
   end
   logic [4:0] ev;
   assign ev = tg_s2_reg ^ tg_s3_reg;
   logic ev_we, ev_wd, ev_cl, ev_sw, ev_st;
   assign ev_we = ev[0];
   assign ev_wd = ev[1];
   assign ev_cl = ev[2];
   assign ev_sw = ev[3];
   assign ev_st = ev[4];
   logic top_sel, lock, deep_power_down;
   assign top_sel = tcb_s2_reg[0];
   assign lock = tcb_s2_reg[1];
   assign deep_power_down = tcb_s2_reg[2];

   // Protection decode
   logic [2:0] size_reg, size_next;
   logic sec_prot;
   fsr_protect_map u_map (
      .size_i(size_reg),
      .top_select_i(top_sel),
      .sector_i(sec_hold_reg),
      .protected_o(sec_prot)
   );

   // State and flags
   fsr_pkg::fsr_state_type state_reg, state_next;
   logic wren_reg, wren_next, perr_reg, perr_next, eerr_reg, eerr_next;
   logic erase_reg, erase_next, go_reg, go_next;
   logic idle, start_ok, start_bad, done_ok, done_bad;
   assign idle = (state_reg == fsr_pkg::FSR_IDLE);
   assign start_ok = ev_st & idle & wren_reg & ~sec_prot;
   assign start_bad = ev_st & idle & wren_reg & sec_prot;
   assign done_ok = (state_reg == fsr_pkg::FSR_RUN) & op_done_i & ~op_fail_i;
   assign done_bad = (state_reg == fsr_pkg::FSR_RUN) & op_done_i & op_fail_i;

   always_comb begin
      state_next = state_reg;
      erase_next = erase_reg;
      perr_next = perr_reg;
      eerr_next = eerr_reg;
      go_next = 1'b0;
      case (state_reg)
         fsr_pkg::FSR_IDLE: begin
            if (start_ok) begin
               state_next = fsr_pkg::FSR_RUN;
               erase_next = er_hold_reg;
               go_next = 1'b1;
            end else if (start_bad) begin
               state_next = fsr_pkg::FSR_HOLD;
               erase_next = er_hold_reg;
               perr_next = ~er_hold_reg;
               eerr_next = er_hold_reg;
            end
         end
         fsr_pkg::FSR_RUN: begin
            if (done_ok) begin
               state_next = fsr_pkg::FSR_IDLE;
            end else if (done_bad) begin
               state_next = fsr_pkg::FSR_HOLD;
               perr_next = ~erase_reg;
               eerr_next = erase_reg;
            end
         end
         fsr_pkg::FSR_HOLD: begin
            if (ev_cl) begin
               state_next = fsr_pkg::FSR_IDLE;
               perr_next = 1'b0;
               eerr_next = 1'b0;
            end
         end
         default: begin
            state_next = fsr_pkg::FSR_IDLE;
         end
      endcase
   end

   // Write enable: set on command, cleared by disable, success, power-down
   always_comb begin
      wren_next = wren_reg;
      if (ev_wd | done_ok | deep_power_down) begin
         wren_next = 1'b0;
      end
      if (ev_we & ~deep_power_down) begin
         wren_next = 1'b1;
      end
   end

   // Size field write: needs write enable, idle, and no lock
   assign size_next = (ev_sw & idle & wren_reg & ~lock) ?
      sz_hold_reg : size_reg;

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         state_reg <= fsr_pkg::FSR_IDLE;
         wren_reg <= 1'b0;
         perr_reg <= 1'b0;
         eerr_reg <= 1'b0;
         erase_reg <= 1'b0;
         go_reg <= 1'b0;
         size_reg <= fsr_pkg::SIZE_RESET;
      end else begin
         state_reg <= state_next;
         wren_reg <= wren_next;
         perr_reg <= perr_next;
         eerr_reg <= eerr_next;
         erase_reg <= erase_next;
         go_reg <= go_next;
         size_reg <= size_next;
      end
   end

   // Output image, registered
   logic [7:0] stat_reg;
   logic [2:0] nv_reg;
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         stat_reg <= 8'h00;
         nv_reg <= fsr_pkg::SIZE_RESET;
      end else begin
         stat_reg[7] <= 1'b0;
         stat_reg[fsr_pkg::PRG_ERR_POS] <= perr_reg;
         stat_reg[fsr_pkg::ERS_ERR_POS] <= eerr_reg;
         stat_reg[fsr_pkg::SIZE_HI:fsr_pkg::SIZE_LO] <= size_reg;
         stat_reg[fsr_pkg::WREN_POS] <= wren_reg;
         stat_reg[fsr_pkg::BUSY_POS] <= ~idle;
         nv_reg <= size_reg;
      end
   end
   assign status_one_volatile_o = stat_reg;
   assign status_one_nonvolatile_size_o = nv_reg;
   assign op_go_o = go_reg;

   chk_busy_errors: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) (perr_reg | eerr_reg) |-> !idle)
      else $error("busy dropped while error set");
   chk_err_when_busy: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) $rose(perr_reg | eerr_reg) |-> $past(!idle)
      || $past(ev_st)) else $error("error set outside busy");
   chk_wren_clear: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) done_ok && !ev_we |=> !wren_reg)
      else $error("write enable not cleared");
   chk_wren_set: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) ev_we && !deep_power_down |=> wren_reg)
      else $error("write enable not set");
   chk_wren_dis: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) ev_wd && !ev_we |=> !wren_reg)
      else $error("write disable ignored");
   chk_start_gate: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) go_next |-> wren_reg)
      else $error("operation without write enable");
   chk_lock_size: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) lock |=> $stable(size_reg))
      else $error("size changed while locked");
   chk_busy_out: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) ##1 stat_reg[0] == $past(!idle))
      else $error("busy image wrong");
   chk_dpd_wren: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) deep_power_down |=> !wren_reg)
      else $error("write enable kept in power-down");
   chk_clear_ok: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) ev_cl && state_reg == fsr_pkg::FSR_HOLD
      |=> !perr_reg && !eerr_reg) else $error("flags not cleared");
   chk_size_zero: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) size_reg == 3'h0 |-> !sec_prot)
      else $error("protection with size zero");
   chk_spare_free: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) size_reg == 3'h7 && sec_hold_reg >= 8'hFE
      |-> !sec_prot) else $error("spare sector protected");
   chk_spare_low: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) size_reg == 3'h7 && sec_hold_reg < 8'hFE
      |-> sec_prot) else $error("low sector unprotected");
   chk_go_pulse: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) go_reg |=> !go_reg && !idle)
      else $error("go pulse too long");
   chk_refuse_busy: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) !idle |-> !go_next)
      else $error("operation accepted while busy");
endmodule

/* testbench/fsr_host_model.sv */
// Host controller model: sends one decoded transaction per link frame.
// Assumes the device samples the pulses on the rising link clock edge.
`timescale 1ns/100ps
module fsr_host_model (
   // Link clock and transaction pulses
   output logic link_clk_o,
   output logic wren_o,
   output logic wrdi_o,
   output logic clear_o,
   output logic size_wr_o,
   output logic [2:0] size_o,
   output logic start_o,
   output logic erase_o,
   output logic [7:0] sector_o
);
   initial begin
      {link_clk_o, wren_o, wrdi_o, clear_o, size_wr_o, start_o} = 6'h00;
      {erase_o, size_o, sector_o} = 12'h000;
   end
   // Kind 0 wren, 1 wrdi, 2 clear, 3 size, 4 op, other idle
   task automatic send(input logic [2:0] kind, input logic [8:0] arg);
      wren_o = (kind == 3'h0);
      wrdi_o = (kind == 3'h1);
      clear_o = (kind == 3'h2);
      size_wr_o = (kind == 3'h3);
      start_o = (kind == 3'h4);
      {erase_o, sector_o} = arg;
      size_o = arg[2:0];
      #16 link_clk_o = 1'b1;
      #16 link_clk_o = 1'b0;
      {wren_o, wrdi_o, clear_o, size_wr_o, start_o} = 5'h00;
      // Released data lines show the inverse, not the last value
      {erase_o, sector_o, size_o} = ~{erase_o, sector_o, size_o};
      #16 link_clk_o = 1'b1;
      #16 link_clk_o = 1'b0;
   endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the status register one logic.
// Assumes a host model on the link and an engine stub driven here.
`timescale 1ns/100ps
module tb;
   typedef struct packed {
      logic [2:0] kind;
      logic [8:0] arg;
      logic fail;
      logic go;
      logic [7:0] exp;
   } fsr_row_type;
   logic ref_clk_i, resetn_i, link_clk, wren, wrdi, clr, size_wr, start;
   logic erase, op_done_i, op_fail_i, lock_i, dpd_i, op_go_o, fail_now;
   logic [2:0] size_data, size_o;
   logic [7:0] sector, status_o;
   int fails = 0;
   int check_count = 0;
   int go_count = 0;
   int go_before;
   fsr_row_type rows [18] = '{
      '{3'h0, 9'h000, 1'b0, 1'b0, 8'h02},
      '{3'h4, 9'h0FF, 1'b0, 1'b1, 8'h00},
      '{3'h0, 9'h000, 1'b0, 1'b0, 8'h02},
      '{3'h3, 9'h001, 1'b0, 1'b0, 8'h06},
      '{3'h4, 9'h000, 1'b0, 1'b1, 8'h04},
      '{3'h4, 9'h000, 1'b0, 1'b0, 8'h04},
      '{3'h0, 9'h000, 1'b0, 1'b0, 8'h06},
      '{3'h1, 9'h000, 1'b0, 1'b0, 8'h04},
      '{3'h0, 9'h000, 1'b0, 1'b0, 8'h06},
      '{3'h4, 9'h0FC, 1'b0, 1'b0, 8'h47},
      '{3'h2, 9'h000, 1'b0, 1'b0, 8'h06},
      '{3'h4, 9'h100, 1'b1, 1'b1, 8'h27},
      '{3'h2, 9'h000, 1'b0, 1'b0, 8'h06},
      '{3'h3, 9'h007, 1'b0, 1'b0, 8'h1E},
      '{3'h4, 9'h1FE, 1'b0, 1'b1, 8'h1C},
      '{3'h0, 9'h000, 1'b0, 1'b0, 8'h1E},
      '{3'h4, 9'h1FD, 1'b0, 1'b0, 8'h3F},
      '{3'h2, 9'h000, 1'b0, 1'b0, 8'h1E}};
   fsr_host_model host (.link_clk_o(link_clk), .wren_o(wren),
      .wrdi_o(wrdi), .clear_o(clr), .size_wr_o(size_wr), .size_o(size_data),
      .start_o(start), .erase_o(erase), .sector_o(sector));
   fsr_status_one DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .link_clk_i(link_clk), .write_enable_cmd_i(wren),
      .write_disable_cmd_i(wrdi), .clear_flags_cmd_i(clr),
      .size_write_cmd_i(size_wr), .size_data_i(size_data),
      .op_start_i(start), .op_is_erase_i(erase), .op_sector_i(sector),
      .op_done_i(op_done_i), .op_fail_i(op_fail_i),
      .top_bottom_select_i(1'b1), .permanent_protect_lock_i(lock_i),
      .deep_power_down_i(dpd_i), .status_one_volatile_o(status_o),
      .status_one_nonvolatile_size_o(size_o), .op_go_o(op_go_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   task automatic check_val(input string name, input logic [7:0] exp,
                            input logic [7:0] got);
      check_count++;
      if (exp !== got) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic settle;
      repeat (14) @(posedge ref_clk_i);
   endtask
   // Engine stub: answers each accepted operation after a short run
   initial forever begin
      @(posedge ref_clk_i);
      if (op_go_o === 1'b1) begin
         go_count++;
         repeat (3) @(posedge ref_clk_i);
         check_val("busy", 8'h01, {7'h00, status_o[0]});
         op_done_i <= 1'b1;
         op_fail_i <= fail_now;
         @(posedge ref_clk_i);
         {op_done_i, op_fail_i} <= 2'h0;
      end
   end
   initial begin
      #200000;
      fails++;
      tally_and_finish();
   end
   initial begin
      {resetn_i, op_done_i, op_fail_i, lock_i, dpd_i, fail_now} = 6'h00;
      host.send(3'h7, 9'h000);
      host.send(3'h7, 9'h000);
      repeat (6) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      host.send(3'h7, 9'h000);
      repeat (4) @(posedge ref_clk_i);
      foreach (rows[i]) begin
         fail_now = rows[i].fail;
         go_before = go_count;
         host.send(rows[i].kind, rows[i].arg);
         settle();
         check_val("status", rows[i].exp, status_o);
         check_val("size", {5'h00, rows[i].exp[4:2]}, {5'h00, size_o});
         check_val("go", {7'h00, rows[i].go}, 8'(go_count - go_before));
      end
      lock_i <= 1'b1;
      settle();
      host.send(3'h3, 9'h003);
      settle();
      check_val("locked size", 8'h07, {5'h00, size_o});
      check_val("locked status", 8'h1E, status_o);
      @(posedge ref_clk_i);
      {lock_i, dpd_i} <= 2'h1;
      settle();
      dpd_i <= 1'b0;
      settle();
      check_val("status after dpd", 8'h1C, status_o);
      host.send(3'h0, 9'h000);
      settle();
      resetn_i <= 1'b0;
      host.send(3'h7, 9'h000);
      host.send(3'h7, 9'h000);
      repeat (6) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      check_val("status after reset", 8'h00, status_o);
      tally_and_finish();
   end
endmodule
